// ===== sai_convert.sv
`timescale 1ns/1ps
module sai_convert #(
  parameter int RESULT_W = sai_pkg::RESULT_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic single_ended_select_i,
  input wire logic odd_sign_i,
  input wire logic [RESULT_W-1:0] analog_channel_zero_i,
  input wire logic [RESULT_W-1:0] analog_channel_one_i,
  output logic [RESULT_W-1:0] result_o
);

  // unipolar difference, clamped at zero like a span that cannot go negative
  function automatic logic [RESULT_W-1:0] diff_clamp(input logic [RESULT_W-1:0] pos,
                                                     input logic [RESULT_W-1:0] neg);
    diff_clamp = (pos > neg) ? RESULT_W'(pos - neg) : '0;
  endfunction

  logic [RESULT_W-1:0] code_next;

  always_comb begin
    if (single_ended_select_i) begin
      code_next = odd_sign_i ? analog_channel_one_i : analog_channel_zero_i;
    end else if (odd_sign_i) begin
      code_next = diff_clamp(analog_channel_one_i, analog_channel_zero_i);
    end else begin
      code_next = diff_clamp(analog_channel_zero_i, analog_channel_one_i);
    end
  end

  // the held sample is converted once, at the end of the sampling window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_o <= '0;
    end else if (start_i) begin
      result_o <= code_next;
    end
  end

  single_ch_a: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i && single_ended_select_i |=>
      result_o == ($past(odd_sign_i) ? $past(analog_channel_one_i)
                                     : $past(analog_channel_zero_i)))
    else $error("single-ended result does not match the selected channel");

  diff_pol_a: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i && !single_ended_select_i && !odd_sign_i
      && analog_channel_zero_i >= analog_channel_one_i |=>
      result_o == RESULT_W'($past(analog_channel_zero_i) - $past(analog_channel_one_i)))
    else $error("differential result has the wrong polarity");

  result_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !start_i |=> $stable(result_o))
    else $error("result changed without a conversion start");

endmodule // sai_convert

// ===== sai_host_model.sv
`timescale 1ns/1ps
module sai_host_model (
  input wire logic clk_i,
  input wire logic dout_i,
  input wire logic dout_oe_i,
  output logic select_shutdown_n_o,
  output logic shift_clk_o,
  output logic cfg_din_o
);
  logic [19:0] rx;
  int rx_n;

  initial begin
    select_shutdown_n_o = 1'b1;
    shift_clk_o = 1'b0;
    cfg_din_o = 1'b0;
    rx = 20'h0_0000;
    rx_n = 0;
  end

  // one shift period, 3 clk low then 3 clk high; data read at the rise
  task automatic shift_cycle(input logic bit_v);
    @(posedge clk_i);
    cfg_din_o <= bit_v;
    repeat (2) @(posedge clk_i);
    shift_clk_o <= 1'b1;
    if (dout_oe_i === 1'b1) begin
      rx = {rx[18:0], dout_i};
      rx_n++;
    end
    repeat (3) @(posedge clk_i);
    shift_clk_o <= 1'b0;
  endtask

  task automatic frame(input int lead, input logic two_ch, input logic [2:0] cfg,
                       input int cycles);
    rx = 20'h0_0000;
    rx_n = 0;
    @(posedge clk_i);
    select_shutdown_n_o <= 1'b0;
    if (two_ch) begin
      repeat (lead) shift_cycle(1'b0);
      shift_cycle(1'b1);
      for (int i = 2; i >= 0; i--) shift_cycle(cfg[i]);
    end else begin
      shift_cycle(1'b1);
    end
    // input keeps toggling after the word; the device must ignore it
    for (int i = 0; i < cycles; i++) shift_cycle(i[0]);
    @(posedge clk_i);
    select_shutdown_n_o <= 1'b1;
    cfg_din_o <= 1'b0;
  endtask
endmodule // sai_host_model

// ===== sai_pkg.sv
package sai_pkg;

  // conversion word and serial framing
  localparam int RESULT_W = 8;
  localparam int CFG_BITS = 3;
  localparam int SAMPLE_FALLS = 2;
  localparam int XFER_CNT_W = 16;

  // captured configuration word, first bit after the start bit ends on top
  localparam int CFG_SGL_BIT = 2;
  localparam int CFG_ODD_BIT = 1;
  localparam int CFG_MSB_FIRST_ONLY_BIT = 0;
  localparam logic [2:0] CFG_RST = 3'h0;

  // register byte offsets on the wishbone bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_CONFIG = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h10;

  // control fields
  localparam int CTRL_TWO_CH_BIT = 0;
  localparam logic CTRL_TWO_CH_RST = 1'b1;

  // status fields
  localparam int STAT_POWER_BIT = 0;
  localparam int STAT_NEW_BIT = 1;
  localparam int STAT_OE_BIT = 2;
  localparam int STAT_STATE_LSB = 4;

  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
  localparam logic [7:0] RESULT_RST = 8'h00;

  typedef enum logic [2:0] {
    SAI_IDLE = 3'b000,
    SAI_WAIT = 3'b001,
    SAI_CONFIG = 3'b010,
    SAI_SAMPLE = 3'b011,
    SAI_SHIFT_MSB = 3'b100,
    SAI_SHIFT_LSB = 3'b101,
    SAI_ZERO_FILL = 3'b110
  } sai_state_e;

endpackage

// ===== sai_top.sv
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
// How it works
// - select low enables the converter; select high powers down and aborts.
// - every transfer step after leaving idle follows an edge of the host's shift clock.
// - two-channel variant samples the configuration input on shift clock rises.
// - first one sampled after select falls is the start bit.
// - zeros sampled before the start bit are ignored.
// - after the configuration word the input is ignored until select recycles.
// - bits after the start bit pick the multiplexer setting for this conversion.
// - single-ended: odd/sign picks channel zero or one against ground.
// - differential: odd/sign zero means channel zero positive; one reverses it.
// - msb-first-only set: result msb first, then zeros until select rises.
// - msb-first-only clear: result msb first, then again lsb first.
// - single-input variant: no configuration, fixed difference, msb then lsb first.
// - result leaves serially on the data output, one bit per shift clock.
// - result is eight bits wide.
// - input is sampled for one and a half shift clocks before converting.
// - each new output bit is driven after a falling shift clock edge.
module sai_top #(
  parameter int XFER_CNT_W = sai_pkg::XFER_CNT_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic select_shutdown_n_i,
  input wire logic shift_clk_i,
  input wire logic cfg_din_i,
  input wire logic [sai_pkg::RESULT_W-1:0] analog_channel_zero_i,
  input wire logic [sai_pkg::RESULT_W-1:0] analog_channel_one_i,
  output logic dout_o,
  output logic dout_oe_o,
  output logic power_on_o
);

  localparam int RW = sai_pkg::RESULT_W;

  function automatic logic pick_bit(input logic [RW-1:0] word, input logic [2:0] idx);
    pick_bit = word[idx];
  endfunction

  logic sclk_prev_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic sel_high;
  sai_pkg::sai_state_e state_reg;
  sai_pkg::sai_state_e state_next;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic [2:0] cfg_reg;
  logic two_ch_reg;
  logic two_ch_xfer_reg;
  logic conv_start;
  logic [RW-1:0] result_w;
  logic dout_reg;
  logic oe_reg;
  logic power_reg;
  logic new_reg;
  logic [XFER_CNT_W-1:0] xfer_cnt_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic msb_first_only_only;

  assign sel_high = select_shutdown_n_i;
  assign msb_first_only_only = two_ch_xfer_reg & cfg_reg[sai_pkg::CFG_MSB_FIRST_ONLY_BIT];

  // shift clock is an ordinary synchronous input; edges are found against last cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= shift_clk_i;
    end
  end

  assign sclk_rise = shift_clk_i & ~sclk_prev_reg;
  assign sclk_fall = ~shift_clk_i & sclk_prev_reg;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    conv_start = 1'b0;
    if (sel_high) begin
      state_next = sai_pkg::SAI_IDLE;
      cnt_next = 3'h0;
    end else begin
      unique case (state_reg)
        sai_pkg::SAI_IDLE: state_next = sai_pkg::SAI_WAIT;
        sai_pkg::SAI_WAIT: begin
          if (sclk_rise) begin
            if (!two_ch_xfer_reg) begin
              state_next = sai_pkg::SAI_SAMPLE;
              cnt_next = 3'h0;
            end else if (cfg_din_i) begin
              state_next = sai_pkg::SAI_CONFIG;
              cnt_next = 3'h0;
            end
          end
        end
        sai_pkg::SAI_CONFIG: begin
          if (sclk_rise) begin
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == 3'(sai_pkg::CFG_BITS - 1)) begin
              state_next = sai_pkg::SAI_SAMPLE;
              cnt_next = 3'h0;
            end
          end
        end
        sai_pkg::SAI_SAMPLE: begin
          if (sclk_fall) begin
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == 3'(sai_pkg::SAMPLE_FALLS - 1)) begin
              conv_start = 1'b1;
              state_next = sai_pkg::SAI_SHIFT_MSB;
              cnt_next = 3'h0;
            end
          end
        end
        sai_pkg::SAI_SHIFT_MSB: begin
          if (sclk_fall) begin
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == 3'h7) begin
              state_next = msb_first_only_only ? sai_pkg::SAI_ZERO_FILL
                                     : sai_pkg::SAI_SHIFT_LSB;
            end
          end
        end
        sai_pkg::SAI_SHIFT_LSB: begin
          if (sclk_fall) begin
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == 3'h7) begin
              state_next = sai_pkg::SAI_ZERO_FILL;
            end
          end
        end
        sai_pkg::SAI_ZERO_FILL: state_next = sai_pkg::SAI_ZERO_FILL;
        default: begin
          state_next = sai_pkg::SAI_IDLE;
          cnt_next = 3'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= sai_pkg::SAI_IDLE;
      cnt_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // variant is frozen for the whole transfer so a bus write cannot split one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      two_ch_xfer_reg <= sai_pkg::CTRL_TWO_CH_RST;
    end else if (state_reg == sai_pkg::SAI_IDLE) begin
      two_ch_xfer_reg <= two_ch_reg;
    end
  end

  // configuration word, shifted in on rises after the start bit only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg <= sai_pkg::CFG_RST;
    end else if (!sel_high && sclk_rise) begin
      if (state_reg == sai_pkg::SAI_WAIT && (cfg_din_i || !two_ch_xfer_reg)) begin
        cfg_reg <= sai_pkg::CFG_RST;
      end else if (state_reg == sai_pkg::SAI_CONFIG) begin
        cfg_reg <= {cfg_reg[1:0], cfg_din_i};
      end
    end
  end

  sai_convert #(
    .RESULT_W(RW)
  ) u_convert (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(conv_start),
    .single_ended_select_i(cfg_reg[sai_pkg::CFG_SGL_BIT]),
    .odd_sign_i(cfg_reg[sai_pkg::CFG_ODD_BIT]),
    .analog_channel_zero_i(analog_channel_zero_i),
    .analog_channel_one_i(analog_channel_one_i),
    .result_o(result_w)
  );

  // serial output, changed only on falling shift clock edges, and cleared by reset or while select is high
  always_ff @(posedge clk_i) begin
    if (rst_i || sel_high) begin
      dout_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (sclk_fall) begin
      unique case (state_reg)
        sai_pkg::SAI_SAMPLE: begin
          if (cnt_reg == 3'(sai_pkg::SAMPLE_FALLS - 1)) begin
            dout_reg <= 1'b0;
            oe_reg <= 1'b1;
          end
        end
        sai_pkg::SAI_SHIFT_MSB: dout_reg <= pick_bit(result_w, ~cnt_reg);
        sai_pkg::SAI_SHIFT_LSB: dout_reg <= pick_bit(result_w, cnt_reg);
        sai_pkg::SAI_ZERO_FILL: dout_reg <= 1'b0;
        default: dout_reg <= dout_reg;
      endcase
    end
  end

  assign dout_o = dout_reg;
  assign dout_oe_o = oe_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_reg <= 1'b0;
    end else begin
      power_reg <= ~sel_high;
    end
  end

  assign power_on_o = power_reg;

  // wishbone classic slave: ack one cycle after the request, dropped the next
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign bus_wr = bus_req & wb_we_i;
  assign bus_rd = bus_req & ~wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
    end
  end

  assign wb_ack_o = ack_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      two_ch_reg <= sai_pkg::CTRL_TWO_CH_RST;
    end else if (bus_wr && wb_sel_i[0] && wb_adr_i == sai_pkg::OFS_CTRL) begin
      two_ch_reg <= wb_dat_i[sai_pkg::CTRL_TWO_CH_BIT];
    end
  end

  // fresh-result flag: a new conversion wins over a read of the result
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      new_reg <= 1'b0;
    end else if (conv_start) begin
      new_reg <= 1'b1;
    end else if (bus_rd && wb_adr_i == sai_pkg::OFS_RESULT) begin
      new_reg <= 1'b0;
    end
  end

  // completed conversions; a write clears it, a conversion in the same cycle counts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xfer_cnt_reg <= '0;
    end else if (bus_wr && wb_adr_i == sai_pkg::OFS_COUNT) begin
      xfer_cnt_reg <= XFER_CNT_W'(conv_start);
    end else if (conv_start) begin
      xfer_cnt_reg <= xfer_cnt_reg + XFER_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= sai_pkg::RDATA_ZERO;
    end else if (bus_rd) begin
      unique case (wb_adr_i)
        sai_pkg::OFS_CTRL: rdata_reg <= 32'(two_ch_reg);
        sai_pkg::OFS_STATUS: rdata_reg <= 32'({state_reg, 1'b0, oe_reg, new_reg, power_reg});
        sai_pkg::OFS_RESULT: rdata_reg <= 32'(result_w);
        sai_pkg::OFS_CONFIG: rdata_reg <= 32'(cfg_reg);
        sai_pkg::OFS_COUNT: rdata_reg <= 32'(xfer_cnt_reg);
        default: rdata_reg <= sai_pkg::RDATA_ZERO;
      endcase
    end
  end

  assign wb_dat_o = rdata_reg;

  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  shutdown_idle_a: assert property (
    sel_high |=> state_reg == sai_pkg::SAI_IDLE && !power_on_o)
    else $error("select high did not end the transfer");

  shutdown_hiz_a: assert property (
    sel_high |=> !dout_oe_o)
    else $error("data output driven while select is high");

  start_bit_a: assert property (
    !sel_high && state_reg == sai_pkg::SAI_WAIT && two_ch_xfer_reg && sclk_rise && cfg_din_i
      |=> state_reg == sai_pkg::SAI_CONFIG)
    else $error("start bit not taken");

  lead_zero_a: assert property (
    !sel_high && state_reg == sai_pkg::SAI_WAIT && two_ch_xfer_reg && !cfg_din_i
      |=> state_reg == sai_pkg::SAI_WAIT)
    else $error("leading zero left the wait state");

  cfg_frozen_a: assert property (
    !sel_high && state_reg inside {sai_pkg::SAI_SAMPLE, sai_pkg::SAI_SHIFT_MSB,
      sai_pkg::SAI_SHIFT_LSB, sai_pkg::SAI_ZERO_FILL} |=> $stable(cfg_reg))
    else $error("configuration changed after it was complete");

  single_var_a: assert property (
    !sel_high && state_reg == sai_pkg::SAI_WAIT && !two_ch_xfer_reg && sclk_rise
      |=> state_reg == sai_pkg::SAI_SAMPLE && cfg_reg == sai_pkg::CFG_RST)
    else $error("single-input variant did not start sampling");

  sample_len_a: assert property (
    conv_start |-> state_reg == sai_pkg::SAI_SAMPLE && sclk_fall
      && cnt_reg == 3'(sai_pkg::SAMPLE_FALLS - 1))
    else $error("conversion started before the sampling window ended");

  fall_only_a: assert property (
    $changed(dout_o) && !$past(sel_high) |-> $past(sclk_fall))
    else $error("data output changed without a falling shift clock");

  null_bit_a: assert property (
    $rose(dout_oe_o) |-> !dout_o ##1 state_reg == sai_pkg::SAI_SHIFT_MSB || sel_high)
    else $error("first driven bit is not a null bit");

  float_early_a: assert property (
    state_reg inside {sai_pkg::SAI_IDLE, sai_pkg::SAI_WAIT, sai_pkg::SAI_CONFIG,
      sai_pkg::SAI_SAMPLE} |-> !dout_oe_o)
    else $error("data output driven before the null bit");

  msb_order_a: assert property (
    !sel_high && state_reg == sai_pkg::SAI_SHIFT_MSB && sclk_fall
      |=> dout_o == result_w[~$past(cnt_reg)] && dout_oe_o)
    else $error("msb-first bit out of order");

  lsb_order_a: assert property (
    !sel_high && state_reg == sai_pkg::SAI_SHIFT_LSB && sclk_fall
      |=> dout_o == result_w[$past(cnt_reg)])
    else $error("lsb-first bit out of order");

  zero_fill_a: assert property (
    !sel_high && state_reg == sai_pkg::SAI_ZERO_FILL && sclk_fall |=> !dout_o)
    else $error("zero fill not driven");

  bus_ack_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle after the request");

endmodule // sai_top

// ===== tb_sai_top.sv
`timescale 1ns/1ps
module tb_sai_top;
  typedef struct packed {
    logic [3:0] lead;
    logic [2:0] cfg;
    logic [7:0] ch0;
    logic [7:0] ch1;
    logic [7:0] code;
  } sai_row_s;

  logic clk_i = 1'b0;
  logic rst_i;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [3:0] wb_sel_i;
  logic wb_we_i;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic sel_n;
  logic sck;
  logic din;
  logic [7:0] ch0;
  logic [7:0] ch1;
  logic dout_o;
  logic dout_oe_o;
  logic power_on_o;
  logic [31:0] rd;
  logic [7:0] code;
  int failures = 0;
  int samples_checked = 0;
  sai_row_s rows [8] = '{
    '{4'h0, 3'h4, 8'hA5, 8'h3C, 8'hA5}, '{4'h2, 3'h5, 8'hA5, 8'h3C, 8'hA5},
    '{4'h1, 3'h6, 8'h5A, 8'hC3, 8'hC3}, '{4'h3, 3'h7, 8'h5A, 8'h81, 8'h81},
    '{4'h0, 3'h0, 8'h90, 8'h30, 8'h60}, '{4'h1, 3'h1, 8'h20, 8'hF1, 8'h00},
    '{4'h0, 3'h2, 8'h11, 8'hFF, 8'hEE}, '{4'h2, 3'h3, 8'h40, 8'h10, 8'h00}};

  always #12.5 clk_i = ~clk_i;

  sai_top i_sai_top (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .select_shutdown_n_i(sel_n),
    .shift_clk_i(sck), .cfg_din_i(din), .analog_channel_zero_i(ch0),
    .analog_channel_one_i(ch1), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
    .power_on_o(power_on_o));

  sai_host_model i_host_model (.clk_i(clk_i), .dout_i(dout_o), .dout_oe_i(dout_oe_o),
    .select_shutdown_n_o(sel_n), .shift_clk_o(sck), .cfg_din_o(din));

  // null bit, msb-first word, lsb-first copy or zeros, then zero fill
  function automatic logic [19:0] exp_stream(input logic [7:0] v, input logic msb_first_only);
    logic [7:0] r;
    r = {<<{v}};
    return {1'b0, v, msb_first_only ? 8'h00 : r, 3'h0};
  endfunction

  task automatic final_report();
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t register read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bits(input logic [19:0] got, input int got_n, input logic [19:0] exp,
                          input int exp_n);
    samples_checked++;
    if (got !== exp || got_n != exp_n) begin
      failures++;
      $display("Error %0t serial %h/%0d expected %h/%0d", $time, got, got_n, exp, exp_n);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t pin %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wb_xfer(input logic [7:0] adr, input logic we, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_adr_i <= adr;
    wb_we_i <= we;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hF;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      $display("Error %0t bus timeout", $time);
      final_report();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    wb_xfer(adr, 1'b0, 32'h0000_0000);
    chk_reg(rd, exp);
  endtask

  initial begin
    repeat (100000) @(posedge clk_i);
    failures++;
    $display("Error %0t run timeout", $time);
    final_report();
  end

  initial begin
    rst_i = 1'b1;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0000_0000;
    wb_sel_i = 4'h0;
    wb_we_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    ch0 = 8'h00;
    ch1 = 8'h00;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_pin(dout_oe_o, 1'b0);
    chk_pin(power_on_o, 1'b0);
    rd_chk(sai_pkg::OFS_CTRL, 32'h0000_0001);
    rd_chk(sai_pkg::OFS_STATUS, 32'h0000_0000);
    rd_chk(sai_pkg::OFS_COUNT, 32'h0000_0000);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_i);
      ch0 <= rows[k].ch0;
      ch1 <= rows[k].ch1;
      code = rows[k].code;
      i_host_model.frame(int'(rows[k].lead), 1'b1, rows[k].cfg, 21);
      repeat (2) @(posedge clk_i);
      chk_bits(i_host_model.rx, i_host_model.rx_n, exp_stream(code, rows[k].cfg[0]),
               20);
      chk_pin(dout_oe_o, 1'b0);
      rd_chk(sai_pkg::OFS_STATUS, 32'h0000_0002);
      rd_chk(sai_pkg::OFS_RESULT, {24'h00_0000, code});
      rd_chk(sai_pkg::OFS_CONFIG, {29'h0000_0000, rows[k].cfg});
      rd_chk(sai_pkg::OFS_COUNT, 32'(k + 1));
    end
    rd_chk(sai_pkg::OFS_STATUS, 32'h0000_0000);
    wb_xfer(8'h14, 1'b1, 32'hFFFF_FFFF);
    rd_chk(8'h14, 32'h0000_0000);
    wb_xfer(sai_pkg::OFS_COUNT, 1'b1, 32'h0000_0001);
    rd_chk(sai_pkg::OFS_COUNT, 32'h0000_0000);
    // abort in the middle of the msb-first word
    @(posedge clk_i);
    ch0 <= 8'hC6;
    fork
      i_host_model.frame(0, 1'b1, 3'h4, 5);
      begin
        repeat (6) @(posedge clk_i);
        chk_pin(power_on_o, 1'b1);
        chk_pin(dout_oe_o, 1'b0);
        rd_chk(sai_pkg::OFS_STATUS, 32'h0000_0021);
      end
    join
    repeat (2) @(posedge clk_i);
    chk_bits(i_host_model.rx, i_host_model.rx_n, 20'h0_0006, 4);
    chk_pin(dout_oe_o, 1'b0);
    chk_pin(power_on_o, 1'b0);
    // single-input variant: configuration input ignored, both orders
    wb_xfer(sai_pkg::OFS_CTRL, 1'b1, 32'h0000_0000);
    @(posedge clk_i);
    ch0 <= 8'hB7;
    ch1 <= 8'h24;
    i_host_model.frame(0, 1'b0, 3'h7, 21);
    repeat (2) @(posedge clk_i);
    chk_bits(i_host_model.rx, i_host_model.rx_n, exp_stream(8'h93, 1'b0), 20);
    rd_chk(sai_pkg::OFS_CONFIG, 32'h0000_0000);
    rd_chk(sai_pkg::OFS_RESULT, 32'h0000_0093);
    // reset in mid-run brings back the register defaults
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(sai_pkg::OFS_CTRL, 32'h0000_0001);
    rd_chk(sai_pkg::OFS_COUNT, 32'h0000_0000);
    chk_pin(power_on_o, 1'b0);
    final_report();
  end
endmodule // tb_sai_top
